// >>> auto_reload_timer_three.sv
// Auto-reload timer three: 16-bit or split dual 8-bit counter with overflow flags.
// Assumes all inputs synchronous to mclk except ext_osc, which is synchronised here.
//
// Functional notes
// - 16-bit counter of two bytes, or two 8-bit auto-reload counters by split bit.
// - Counter advances from system clock, system clock over 12, or external over 8.
// - External oscillator is resynchronised into system clock domain before it is divided.
// - 16-bit wrap loads the reload value and sets the high overflow flag.
// - 16-bit mode requests an interrupt on every full overflow when enabled.
// - 16-bit mode with low irq enable also requests on low byte wrap.
// - Split mode: each byte reloads from its own reload byte.
// - Split mode: run control gates only the high counter; low always runs.
// - Split mode: byte clock select one picks the system clock.
// - Clock select zero picks system over 12 or external over 8.
// - Split mode: each byte wrap sets its own overflow flag.
// - Split mode: high overflow requests; with low enable, either byte requests.
// - Flags are cleared only by software; hardware never clears them.
// - Capture enable with the timer irq enable copies count into reload and requests on oscillator rise.
// - 16-bit mode: run control starts and stops the whole counter.
`timescale 1ns/1ps
module auto_reload_timer_three
	import timer_three_pkg::*;
#(
	// Prescaler counts; the divider counters hold at most 16 and 8
	parameter int SYS_DIVIDE = SYS_DIV,
	parameter int EXT_DIVIDE = EXT_DIV
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Special function register port
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] timer_three_control,
	// Reload and count preset, written by software
	input wire logic reload_low_wr,
	input wire logic reload_high_wr,
	input wire logic count_low_wr,
	input wire logic count_high_wr,
	input wire logic [7:0] byte_wdata,
	// Clock selects and interrupt enable from elsewhere
	input wire logic low_clock_select,
	input wire logic high_clock_select,
	input wire logic timer_irq_enable,
	// External oscillator and low-frequency oscillator
	input wire logic ext_osc,
	input wire logic lfo_out,
	// State and interrupt request
	output logic [7:0] count_low_byte,
	output logic [7:0] count_high_byte,
	output logic [7:0] reload_low_byte,
	output logic [7:0] reload_high_byte,
	output logic irq
);

////////////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrl, next_ctrl;
	logic [7:0] cnt_lo, next_cnt_lo, cnt_hi, next_cnt_hi;
	logic [7:0] rl_lo, next_rl_lo, rl_hi, next_rl_hi;
	logic [3:0] div12, next_div12;
	logic [2:0] div8, next_div8;
	logic ext_rise;
	logic ext_s1, ext_s2, ext_s3;
	logic lfo_q, next_lfo_q;
	logic irq_q, next_irq_q;
	logic tick12, tick_ext, tick_sel, tick_lo, tick_hi;
	logic split, run, wrap_lo, wrap_hi, wrap16, lfo_rise, capture;

	assign split = ctrl[SPLIT_BIT];
	assign run = ctrl[RUN_BIT];

	// Divider widths cannot serve larger counts
	if (SYS_DIVIDE < 2 || SYS_DIVIDE > 16) begin : g_sys_div_check
		$error("system clock divider out of range");
	end
	if (EXT_DIVIDE < 2 || EXT_DIVIDE > 8) begin : g_ext_div_check
		$error("external clock divider out of range");
	end

////////////////////////////////////////////////////////////////////////////////
	// Prescalers and external tick crossing
	always_comb begin
		next_div12 = tick12 ? 4'h0 : div12 + 4'h1;
		// External edges are counted after the synchroniser
		next_div8 = div8;
		if (ext_rise) begin
			next_div8 = (div8 == 3'(EXT_DIVIDE - 1)) ? 3'h0 : div8 + 3'h1;
		end
		next_lfo_q = lfo_out;
	end
	assign tick12 = (div12 == 4'(SYS_DIVIDE - 1));

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			div12 <= 4'h0;
			div8 <= 3'h0;
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			lfo_q <= 1'b0;
		end else begin
			div12 <= next_div12;
			div8 <= next_div8;
			ext_s1 <= ext_osc;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			lfo_q <= next_lfo_q;
		end
	end
	// Oscillator must stay below half of mclk, or edges are lost
	assign ext_rise = ext_s2 & ~ext_s3;
	// One tick per divided period, on the synchronised rising edge
	assign tick_ext = ext_rise && div8 == 3'(EXT_DIVIDE - 1);

////////////////////////////////////////////////////////////////////////////////
	// Clock source choice per byte
	assign tick_sel = ctrl[EXT_SEL_BIT] ? tick_ext : tick12;
	always_comb begin
		if (split) begin
			tick_lo = low_clock_select ? 1'b1 : tick_sel;
			tick_hi = (high_clock_select ? 1'b1 : tick_sel) & run;
		end else begin
			// Whole counter shares the low byte's select
			tick_lo = (low_clock_select ? 1'b1 : tick_sel) & run;
			tick_hi = tick_lo;
		end
	end

	assign wrap_lo = tick_lo && cnt_lo == BYTE_ONES;
	assign wrap_hi = split ? (tick_hi && cnt_hi == BYTE_ONES) : 1'b0;
	assign wrap16 = !split && wrap_lo && cnt_hi == BYTE_ONES;
	assign lfo_rise = lfo_out & ~lfo_q;
	assign capture = lfo_rise && ctrl[CAPTURE_EN_BIT] && timer_irq_enable;

////////////////////////////////////////////////////////////////////////////////
	// Counter, reload and control next state
	always_comb begin
		next_cnt_lo = cnt_lo;
		next_cnt_hi = cnt_hi;
		next_rl_lo = reload_low_wr ? byte_wdata : rl_lo;
		next_rl_hi = reload_high_wr ? byte_wdata : rl_hi;
		next_ctrl = ctrl;
		next_irq_q = 1'b0;
		if (sfr_wr && sfr_addr == CTRL_ADDR) begin
			next_ctrl = sfr_wdata & CTRL_WMASK;
		end
		if (split) begin
			if (wrap_lo) begin
				next_cnt_lo = rl_lo;
			end else if (tick_lo) begin
				next_cnt_lo = cnt_lo + 8'h01;
			end
			if (wrap_hi) begin
				next_cnt_hi = rl_hi;
			end else if (tick_hi) begin
				next_cnt_hi = cnt_hi + 8'h01;
			end
			if (wrap_hi) begin
				next_ctrl[HIGH_FLAG_BIT] = 1'b1;
			end
			if (wrap_lo) begin
				next_ctrl[LOW_FLAG_BIT] = 1'b1;
			end
			next_irq_q = timer_irq_enable &&
				(wrap_hi || (wrap_lo && ctrl[LOW_IRQ_EN_BIT]));
		end else begin
			if (wrap16) begin
				next_cnt_lo = rl_lo;
				next_cnt_hi = rl_hi;
				next_ctrl[HIGH_FLAG_BIT] = 1'b1;
			end else if (tick_lo) begin
				{next_cnt_hi, next_cnt_lo} = {cnt_hi, cnt_lo} + 16'h0001;
			end
			if (wrap_lo && !wrap16) begin
				next_ctrl[LOW_FLAG_BIT] = 1'b1;
			end
			next_irq_q = timer_irq_enable &&
				(wrap16 || (wrap_lo && ctrl[LOW_IRQ_EN_BIT]));
		end
		// Preset writes win over counting
		if (count_low_wr) begin
			next_cnt_lo = byte_wdata;
		end
		if (count_high_wr) begin
			next_cnt_hi = byte_wdata;
		end
		if (capture) begin
			next_rl_lo = cnt_lo;
			next_rl_hi = cnt_hi;
			next_irq_q = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl <= CTRL_RESET;
			cnt_lo <= BYTE_ZERO;
			cnt_hi <= BYTE_ZERO;
			rl_lo <= BYTE_ZERO;
			rl_hi <= BYTE_ZERO;
			irq_q <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			cnt_lo <= next_cnt_lo;
			cnt_hi <= next_cnt_hi;
			rl_lo <= next_rl_lo;
			rl_hi <= next_rl_hi;
			irq_q <= next_irq_q;
		end
	end

	assign timer_three_control = ctrl;
	assign count_low_byte = cnt_lo;
	assign count_high_byte = cnt_hi;
	assign reload_low_byte = rl_lo;
	assign reload_high_byte = rl_hi;
	assign irq = irq_q;

////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_full_wrap;
		!split && tick_lo && cnt_lo == BYTE_ONES && cnt_hi == BYTE_ONES
			&& !count_low_wr && !count_high_wr;
	endsequence
	property p_wrap16_reload;
		@(posedge mclk) disable iff (reset)
		s_full_wrap ##1 1'b1 |-> cnt_lo == $past(rl_lo) && ctrl[HIGH_FLAG_BIT];
	endproperty
	a_wrap16_reload: assert property (p_wrap16_reload) else $error("wrap no reload");
	property p_irq16;
		@(posedge mclk) disable iff (reset)
		(s_full_wrap and timer_irq_enable) |=> irq;
	endproperty
	a_irq16: assert property (p_irq16) else $error("no 16-bit irq");
	property p_irq_low16;
		@(posedge mclk) disable iff (reset)
		(!split && wrap_lo && timer_irq_enable && ctrl[LOW_IRQ_EN_BIT]) |=> irq;
	endproperty
	a_irq_low16: assert property (p_irq_low16) else $error("no low irq");
	property p_split_reload;
		@(posedge mclk) disable iff (reset)
		(split && wrap_hi && !count_high_wr) |=> cnt_hi == $past(rl_hi);
	endproperty
	a_split_reload: assert property (p_split_reload) else $error("split no reload");
	property p_low_runs;
		@(posedge mclk) disable iff (reset)
		(split && !run && low_clock_select && !count_low_wr && cnt_lo != BYTE_ONES)
			|=> cnt_lo == $past(cnt_lo) + 8'h01;
	endproperty
	a_low_runs: assert property (p_low_runs) else $error("low stalled");
	property p_stop16;
		@(posedge mclk) disable iff (reset)
		(!split && !run && !count_low_wr && !count_high_wr) |=> $stable(cnt_lo) && $stable(cnt_hi);
	endproperty
	a_stop16: assert property (p_stop16) else $error("ran while stopped");
	property p_flag_sticky;
		@(posedge mclk) disable iff (reset)
		(ctrl[LOW_FLAG_BIT] && !(sfr_wr && sfr_addr == CTRL_ADDR)) |=> ctrl[LOW_FLAG_BIT];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag self-cleared");
	property p_split_flag;
		@(posedge mclk) disable iff (reset)
		wrap_hi |=> ctrl[HIGH_FLAG_BIT];
	endproperty
	a_split_flag: assert property (p_split_flag) else $error("high flag missing");
	property p_unused;
		@(posedge mclk) disable iff (reset)
		1'b1 |-> !ctrl[UNUSED_BIT];
	endproperty
	a_unused: assert property (p_unused) else $error("bit1 set");
	property p_capture;
		@(posedge mclk) disable iff (reset)
		capture |=> rl_lo == $past(cnt_lo) && irq;
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");
	property p_split_low_flag;
		@(posedge mclk) disable iff (reset)
		(split && wrap_lo) |=> ctrl[LOW_FLAG_BIT];
	endproperty
	a_split_low_flag: assert property (p_split_low_flag) else $error("low flag missing");
	property p_split_irq;
		@(posedge mclk) disable iff (reset)
		(split && wrap_hi && timer_irq_enable) |=> irq;
	endproperty
	a_split_irq: assert property (p_split_irq) else $error("no split irq");
	property p_high_runs;
		@(posedge mclk) disable iff (reset)
		(split && run && high_clock_select && !count_high_wr && cnt_hi != BYTE_ONES)
			|=> cnt_hi == $past(cnt_hi) + 8'h01;
	endproperty
	a_high_runs: assert property (p_high_runs) else $error("high byte missed a tick");
	property p_div12_hold;
		@(posedge mclk) disable iff (reset)
		(!split && run && !low_clock_select && !ctrl[EXT_SEL_BIT] && !tick12
			&& !count_low_wr && !count_high_wr) |=> $stable(cnt_lo) && $stable(cnt_hi);
	endproperty
	a_div12_hold: assert property (p_div12_hold) else $error("counted between ticks");
	property p_ext_hold;
		@(posedge mclk) disable iff (reset)
		(!split && run && !low_clock_select && ctrl[EXT_SEL_BIT] && !tick_ext
			&& !count_low_wr && !count_high_wr) |=> $stable(cnt_lo) && $stable(cnt_hi);
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("counted without ext tick");

endmodule : auto_reload_timer_three

// >>> timer_three_pkg.sv
// Package for the auto-reload timer three block.
// Assumes a single system clock domain and an SFR-style register port.
package timer_three_pkg;
	// Register address in the SFR space
	localparam logic [7:0] CTRL_ADDR = 8'h91;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Control register field positions
	localparam int HIGH_FLAG_BIT = 7;
	localparam int LOW_FLAG_BIT = 6;
	localparam int LOW_IRQ_EN_BIT = 5;
	localparam int CAPTURE_EN_BIT = 4;
	localparam int SPLIT_BIT = 3;
	localparam int RUN_BIT = 2;
	localparam int UNUSED_BIT = 1;
	localparam int EXT_SEL_BIT = 0;
	// Writable bits; bit 1 is held at zero
	localparam logic [7:0] CTRL_WMASK = 8'hFD;
	// Prescaler counts
	localparam int SYS_DIV = 12;
	localparam int EXT_DIV = 8;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hFF;
endpackage : timer_three_pkg

// >>> auto_reload_timer_three_tb.sv
// Self-checking bench for the auto-reload timer three block.
// Assumes the block sits alone with every input driven from here.
`timescale 1ns/1ps
module auto_reload_timer_three_tb;
	import timer_three_pkg::*;
	logic mclk = 0;
	logic reset = 1;
	logic sfr_wr = 0;
	logic reload_low_wr = 0;
	logic reload_high_wr = 0;
	logic count_low_wr = 0;
	logic count_high_wr = 0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] byte_wdata = 8'h00;
	logic low_clock_select = 0;
	logic high_clock_select = 0;
	logic timer_irq_enable = 0;
	logic ext_osc = 0;
	logic lfo_out = 0;
	logic ext_run = 0;
	logic [7:0] timer_three_control, count_low_byte, count_high_byte;
	logic [7:0] reload_low_byte, reload_high_byte;
	logic irq;
	logic seen;
	int errors = 0;
	int comparisons = 0;
	always #2.5 mclk = ~mclk;
	// Four mclk periods, toggling on mclk falling edges; ext over 8 gives one tick per 32 cycles
	always #10 if (ext_run) ext_osc = ~ext_osc;
	auto_reload_timer_three dut (.mclk(mclk), .reset(reset), .sfr_wr(sfr_wr),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .timer_three_control(timer_three_control),
		.reload_low_wr(reload_low_wr), .reload_high_wr(reload_high_wr),
		.count_low_wr(count_low_wr), .count_high_wr(count_high_wr), .byte_wdata(byte_wdata),
		.low_clock_select(low_clock_select), .high_clock_select(high_clock_select),
		.timer_irq_enable(timer_irq_enable), .ext_osc(ext_osc), .lfo_out(lfo_out),
		.count_low_byte(count_low_byte), .count_high_byte(count_high_byte),
		.reload_low_byte(reload_low_byte), .reload_high_byte(reload_high_byte), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	task automatic step(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_sfr(logic [7:0] a, logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		step(1);
		sfr_wr = 0;
		step(1);
	endtask : wr_sfr
	task automatic wr_ctrl(logic [7:0] d);
		wr_sfr(CTRL_ADDR, d);
	endtask : wr_ctrl
	// Reload bytes when rl is set, else count bytes; low byte first
	task automatic wr_pair(bit rl, logic [15:0] v);
		byte_wdata = v[7:0];
		if (rl) reload_low_wr = 1; else count_low_wr = 1;
		step(1);
		{reload_low_wr, count_low_wr} = 2'b00;
		byte_wdata = v[15:8];
		if (rl) reload_high_wr = 1; else count_high_wr = 1;
		step(1);
		{reload_high_wr, count_high_wr} = 2'b00;
	endtask : wr_pair
	// Bounded watch for the one-cycle request pulse
	task automatic wait_irq(int max);
		seen = 0;
		for (int i = 0; i < max && seen !== 1'b1; i++) begin
			step(1);
			if (irq === 1'b1) seen = 1;
		end
	endtask : wait_irq
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(timer_three_control, CTRL_RESET);
		wr_ctrl(8'h02);
		chk(timer_three_control, 8'h00);
		wr_sfr(8'h90, 8'h04);
		chk(timer_three_control, 8'h00);
		wr_ctrl(8'hFF);
		chk(timer_three_control, 8'hFD);
		wr_ctrl(8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_wrap16;
		logic [7:0] held;
		low_clock_select = 1;
		timer_irq_enable = 1;
		wr_pair(1, 16'h1234);
		wr_pair(0, 16'h00FA);
		wr_ctrl(8'h04);
		wait_irq(20);
		chk(seen, 0);
		wr_ctrl(8'h00);
		wr_pair(0, 16'h00FA);
		wr_ctrl(8'h24);
		wait_irq(20);
		chk(seen, 1);
		chk(count_high_byte, 8'h01);
		wr_pair(0, 16'hFFFA);
		wait_irq(20);
		chk(seen, 1);
		chk(count_high_byte, 8'h12);
		chk(timer_three_control[HIGH_FLAG_BIT], 1);
		wr_ctrl(8'h00);
		held = count_low_byte;
		step(10);
		chk(count_low_byte, held);
		$display("test wrap16 done");
	endtask : t_wrap16
	task automatic t_split;
		high_clock_select = 1;
		wr_pair(1, 16'h8040);
		wr_pair(0, 16'h10F8);
		wr_ctrl(8'h08);
		wait_irq(20);
		chk(seen, 0);
		chk(timer_three_control[LOW_FLAG_BIT], 1);
		chk(count_high_byte, 8'h10);
		chk(count_low_byte[7:6], 2'b01);
		step(30);
		chk(timer_three_control[LOW_FLAG_BIT], 1);
		wr_ctrl(8'h2C);
		wait_irq(300);
		chk(seen, 1);
		chk(count_low_byte, 8'h40);
		chk(timer_three_control[LOW_FLAG_BIT], 1);
		chk(count_high_byte[7], 1);
		wait_irq(100);
		chk(seen, 1);
		chk(count_high_byte, 8'h80);
		chk(timer_three_control[HIGH_FLAG_BIT], 1);
		$display("test split done");
	endtask : t_split
	task automatic t_clocks;
		wr_ctrl(8'h00);
		low_clock_select = 0;
		wr_pair(0, 16'h0000);
		wr_ctrl(8'h04);
		step(120);
		chk(count_low_byte >= 9 && count_low_byte <= 11, 1);
		wr_ctrl(8'h00);
		wr_pair(0, 16'h0000);
		ext_run = 1;
		wr_ctrl(8'h05);
		step(320);
		chk(count_low_byte >= 9 && count_low_byte <= 11, 1);
		ext_run = 0;
		$display("test clocks done");
	endtask : t_clocks
	task automatic t_capture;
		wr_ctrl(8'h00);
		wr_pair(0, 16'hABCD);
		wr_ctrl(8'h10);
		lfo_out = 1;
		wait_irq(10);
		chk(seen, 1);
		chk({reload_high_byte, reload_low_byte}, 16'hABCD);
		lfo_out = 0;
		$display("test capture done");
	endtask : t_capture
	task automatic t_midreset;
		wr_ctrl(8'h0C);
		step(5);
		reset = 1;
		step(2);
		chk(timer_three_control, CTRL_RESET);
		chk({count_high_byte, count_low_byte}, 16'h0000);
		chk({reload_high_byte, reload_low_byte}, 16'h0000);
		reset = 0;
		step(1);
		chk(timer_three_control, CTRL_RESET);
		chk({count_high_byte, count_low_byte}, 16'h0000);
		chk(irq, 0);
		$display("test midreset done");
	endtask : t_midreset
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	initial begin
		step(4);
		reset = 0;
		step(1);
		t_reset();
		t_wrap16();
		t_split();
		t_clocks();
		t_capture();
		t_midreset();
		end_sim();
	end
	// Tests need about 1000 cycles; this allows twenty times that
	initial begin
		#100000;
		errors++;
		end_sim();
	end
endmodule : auto_reload_timer_three_tb
